// ### design/sdial_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz clock
// Notes: Byte addresses on the plain register port
`ifndef SDIAL_DEFS_SVH
`define SDIAL_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SDIAL_OFS_CTRL 8'h00
`define SDIAL_OFS_SPEED 8'h04
`define SDIAL_OFS_SWPOS 8'h08
`define SDIAL_OFS_SWNEG 8'h0C
`define SDIAL_OFS_ERRLIM 8'h10
`define SDIAL_OFS_COMMTO 8'h14
`define SDIAL_OFS_OFFSET 8'h18
`define SDIAL_OFS_STATUS 8'h1C
`define SDIAL_OFS_POS 8'h20
// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define SDIAL_CTRL_LIMALM 0
`define SDIAL_CTRL_SWALM 1
`define SDIAL_CTRL_MODE_LO 2
`define SDIAL_CTRL_MODE_HI 3
`define SDIAL_CTRL_HSTART 4
`define SDIAL_ST_HOMED 18
`define SDIAL_ST_RUN 19
`define SDIAL_ST_HOMING 20
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDIAL_RST_SPEED 16'h03E8
`define SDIAL_RST_SWPOS 32'h7FFFFFFF
`define SDIAL_RST_SWNEG 32'h80000000
`define SDIAL_RST_ERRLIM 8'h03
`define SDIAL_RST_COMMTO 32'h00000000
`define SDIAL_RST_OFFSET 16'h0000
// ----------------------------------------
// Blink counts and home modes
// ----------------------------------------
`define SDIAL_BL_OVCUR 4'h5
`define SDIAL_BL_HEAT 4'h2
`define SDIAL_BL_VOLT 4'h3
`define SDIAL_BL_PULSE 4'h2
`define SDIAL_BL_MEM 4'h9
`define SDIAL_BL_MOTION 4'h7
`define SDIAL_MODE_3S 2'h0
`define SDIAL_MODE_2S 2'h1
`define SDIAL_MODE_1D 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SDIAL_CLK_KHZ 100000
`define SDIAL_BLINK_ON_MS 200
`define SDIAL_BLINK_OFF_MS 300
`define SDIAL_BLINK_GAP_MS 1500
`define SDIAL_BLINK_ON_CYC (`SDIAL_BLINK_ON_MS * `SDIAL_CLK_KHZ)
`define SDIAL_BLINK_OFF_CYC (`SDIAL_BLINK_OFF_MS * `SDIAL_CLK_KHZ)
`define SDIAL_BLINK_GAP_CYC (`SDIAL_BLINK_GAP_MS * `SDIAL_CLK_KHZ)
`define SDIAL_STEP_MDEG 1800
`define SDIAL_TIM_MDEG 7200
`define SDIAL_TIM_STEPS 16'(`SDIAL_TIM_MDEG / `SDIAL_STEP_MDEG)
`define SDIAL_DECEL_STEPS 16'h0010
`endif

// ### design/sdial_pkg.sv
// Purpose: Types shared by the alarm and I/O logic
// Assumes: Nothing beyond the header
// Notes: Structs carry pin and fault groups
package sdial_pkg;
  typedef struct packed {
    logic sensor_input_a;
    logic rls;
    logic fls;
    logic home;
    logic clr;
    logic stop;
    logic rev;
    logic fwd;
  } sdial_pins_t;

  typedef struct packed {
    logic cpu;
    logic mem;
    logic pulse;
    logic unvolt;
    logic ovvolt;
    logic heat;
    logic ovcur;
  } sdial_fault_t;

  typedef struct packed {
    logic cpu;
    logic comto;
    logic comerr;
    logic offset;
    logic swot;
    logic hwot;
    logic timslit;
    logic nohomes;
    logic homeop;
    logic lsrev;
    logic bothls;
    logic nohome;
    logic mem;
    logic pulse;
    logic unvolt;
    logic ovvolt;
    logic heat;
    logic ovcur;
  } sdial_alarm_t;

  typedef enum logic [3:0] {
    HM_IDLE = 4'h1,
    HM_SEEK = 4'h2,
    HM_DECEL = 4'h4,
    HM_OFFS = 4'h8
  } sdial_home_st_t;

  typedef enum logic [2:0] {
    BL_GAP = 3'h1,
    BL_ON = 3'h2,
    BL_OFF = 3'h4
  } sdial_blink_st_t;
endpackage

// ### design/sdial_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes: A change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sdial_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per bit: hold the last agreed level while stages disagree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout <= '0;
    end else begin
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule
`default_nettype wire

// ### design/sdial_blink.sv
// Purpose: Alarm indicator flash-group generator
// Assumes: Count zero means no alarm
// Notes: Steady request overrides flashing
`timescale 1ns/1ps
`default_nettype none
module sdial_blink #(
  parameter int unsigned ON_CYC = 1,
  parameter int unsigned OFF_CYC = 1,
  parameter int unsigned GAP_CYC = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] count,
  input wire logic steady,
  output logic led
);
  sdial_pkg::sdial_blink_st_t state;
  logic [31:0] timer;
  logic [3:0] left;
  logic expired;

  always_comb begin
    unique case (state)
      sdial_pkg::BL_ON: expired = timer >= ON_CYC - 1;
      sdial_pkg::BL_OFF: expired = timer >= OFF_CYC - 1;
      default: expired = timer >= GAP_CYC - 1;
    endcase
  end

  // Counted flashes, then a long dark pause so the group can be read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= sdial_pkg::BL_GAP;
      timer <= '0;
      left <= '0;
    end else if (count == 4'h0) begin
      state <= sdial_pkg::BL_GAP;
      timer <= '0;
    end else if (!expired) begin
      timer <= timer + 32'h1;
    end else begin
      timer <= '0;
      unique case (state)
        sdial_pkg::BL_GAP: begin
          state <= sdial_pkg::BL_ON;
          left <= count - 4'h1;
        end
        sdial_pkg::BL_ON: state <= sdial_pkg::BL_OFF;
        sdial_pkg::BL_OFF: begin
          if (left == 4'h0) begin
            state <= sdial_pkg::BL_GAP;
          end else begin
            state <= sdial_pkg::BL_ON;
            left <= left - 4'h1;
          end
        end
        default: state <= sdial_pkg::BL_GAP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led <= 1'b0;
    end else begin
      led <= steady || (state == sdial_pkg::BL_ON && count != 4'h0);
    end
  end
endmodule
`default_nettype wire

// ### design/sdial_top.sv
// Purpose: Control inputs, status outputs and protective alarms of a stepper driver
// Assumes: Pins and fault detectors are asynchronous; link events are on clk
// Notes: Any latched alarm stops the motor until cleared
`include "sdial_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdial_top #(
  parameter int unsigned BLINK_ON_CYC = `SDIAL_BLINK_ON_CYC,
  parameter int unsigned BLINK_OFF_CYC = `SDIAL_BLINK_OFF_CYC,
  parameter int unsigned BLINK_GAP_CYC = `SDIAL_BLINK_GAP_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic forwardRunInput,
  input wire logic reverseRunInput,
  input wire logic stopInput,
  input wire logic alarmClearInput,
  input wire logic homeSensorInput,
  input wire logic forwardLimitInput,
  input wire logic reverseLimitInput,
  input wire logic sensorInputA,
  input wire sdial_pkg::sdial_fault_t faultIn,
  input wire logic commFrame,
  input wire logic commError,
  input wire logic absMoveStart,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic alarmContactOutput,
  output logic shaftAnglePulseOutput,
  output logic stepPulse,
  output logic stepDir,
  output logic alarmLed
);
  sdial_pkg::sdial_pins_t pin;
  sdial_pkg::sdial_fault_t flt;
  sdial_pkg::sdial_alarm_t alarm;
  sdial_pkg::sdial_alarm_t setA;
  sdial_pkg::sdial_home_st_t hst;
  logic limAlm;
  logic swAlm;
  logic [1:0] homeMode;
  logic homeStart;
  logic [15:0] speed;
  logic signed [31:0] swPos;
  logic signed [31:0] swNeg;
  logic [7:0] errLim;
  logic [31:0] commTo;
  logic [15:0] offsetSteps;
  logic signed [31:0] pos;
  logic [15:0] timCnt;
  logic [15:0] stepTimer;
  logic [15:0] homeCnt;
  logic homed;
  logic homeDir;
  logic passedLim;
  logic homeDone;
  logic clrPrev;
  logic flsPrev;
  logic rlsPrev;
  logic [7:0] errCnt;
  logic [31:0] idleCnt;
  logic alarmAny;
  logic homing;
  logic wantRun;
  logic moveFwd;
  logic blocked;
  logic stepTick;
  logic limEdge;
  logic clrEdge;
  logic [3:0] blinkCount;

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  sdial_sync #(.W($bits(sdial_pkg::sdial_pins_t) + $bits(sdial_pkg::sdial_fault_t))) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({faultIn, sensorInputA, reverseLimitInput, forwardLimitInput, homeSensorInput,
      alarmClearInput, stopInput, reverseRunInput, forwardRunInput}),
    .dout({flt, pin})
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clrPrev <= 1'b0;
      flsPrev <= 1'b0;
      rlsPrev <= 1'b0;
    end else begin
      clrPrev <= pin.clr;
      flsPrev <= pin.fls;
      rlsPrev <= pin.rls;
    end
  end

  assign clrEdge = pin.clr && !clrPrev;
  assign limEdge = (pin.fls && !flsPrev) || (pin.rls && !rlsPrev);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      limAlm <= 1'b0;
      swAlm <= 1'b0;
      homeMode <= `SDIAL_MODE_3S;
      homeStart <= 1'b0;
      speed <= `SDIAL_RST_SPEED;
      swPos <= `SDIAL_RST_SWPOS;
      swNeg <= `SDIAL_RST_SWNEG;
      errLim <= `SDIAL_RST_ERRLIM;
      commTo <= `SDIAL_RST_COMMTO;
      offsetSteps <= `SDIAL_RST_OFFSET;
    end else begin
      homeStart <= 1'b0;
      if (regWr) begin
        unique case (regAddr)
          `SDIAL_OFS_CTRL: begin
            limAlm <= regWdata[`SDIAL_CTRL_LIMALM];
            swAlm <= regWdata[`SDIAL_CTRL_SWALM];
            homeMode <= regWdata[`SDIAL_CTRL_MODE_HI:`SDIAL_CTRL_MODE_LO];
            homeStart <= regWdata[`SDIAL_CTRL_HSTART];
          end
          `SDIAL_OFS_SPEED: speed <= regWdata[15:0];
          `SDIAL_OFS_SWPOS: swPos <= regWdata;
          `SDIAL_OFS_SWNEG: swNeg <= regWdata;
          `SDIAL_OFS_ERRLIM: errLim <= regWdata[7:0];
          `SDIAL_OFS_COMMTO: commTo <= regWdata;
          `SDIAL_OFS_OFFSET: offsetSteps <= regWdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        `SDIAL_OFS_CTRL: regRdata <= {28'h0, homeMode, swAlm, limAlm};
        `SDIAL_OFS_SPEED: regRdata <= {16'h0, speed};
        `SDIAL_OFS_SWPOS: regRdata <= swPos;
        `SDIAL_OFS_SWNEG: regRdata <= swNeg;
        `SDIAL_OFS_ERRLIM: regRdata <= {24'h0, errLim};
        `SDIAL_OFS_COMMTO: regRdata <= commTo;
        `SDIAL_OFS_OFFSET: regRdata <= {16'h0, offsetSteps};
        `SDIAL_OFS_STATUS: regRdata <= {11'h0, homing, wantRun && !blocked, homed, alarm};
        `SDIAL_OFS_POS: regRdata <= pos;
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------
  // Motion
  // ----------------------------------------
  assign alarmAny = |alarm;
  assign homing = hst != sdial_pkg::HM_IDLE;
  assign moveFwd = homing ? homeDir : pin.fwd;
  // Both run inputs at once cancel; any alarm or stop holds the motor
  assign wantRun = !alarmAny && !pin.stop &&
    (homing || (pin.fwd ^ pin.rev));
  // Outside homing, a limit, or once homed a software limit, refuses travel into it
  assign blocked = !homing && (moveFwd ? (pin.fls || (homed && pos >= swPos))
    : (pin.rls || (homed && pos <= swNeg)));
  assign stepTick = wantRun && !blocked && stepTimer >= speed;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stepTimer <= '0;
    end else if (!wantRun || blocked || stepTick) begin
      stepTimer <= '0;
    end else begin
      stepTimer <= stepTimer + 16'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stepPulse <= 1'b0;
      stepDir <= 1'b0;
    end else begin
      stepPulse <= stepTick;
      stepDir <= moveFwd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos <= '0;
      timCnt <= '0;
      homed <= 1'b0;
    end else if (homeDone) begin
      pos <= '0;
      timCnt <= '0;
      homed <= 1'b1;
    end else if (stepTick) begin
      pos <= moveFwd ? pos + 32'sd1 : pos - 32'sd1;
      if (moveFwd) begin
        timCnt <= (timCnt == `SDIAL_TIM_STEPS - 16'h1) ? 16'h0 : timCnt + 16'h1;
      end else begin
        timCnt <= (timCnt == 16'h0) ? `SDIAL_TIM_STEPS - 16'h1 : timCnt - 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shaftAnglePulseOutput <= 1'b0;
    end else begin
      shaftAnglePulseOutput <= homed && timCnt == 16'h0;
    end
  end

  // ----------------------------------------
  // Return to home
  // ----------------------------------------
  always_comb begin
    setA = '0;
    homeDone = 1'b0;
    unique case (hst)
      sdial_pkg::HM_SEEK: begin
        if (homeMode == `SDIAL_MODE_3S) begin
          if (pin.home) begin
            setA.timslit = !pin.sensor_input_a;
            homeDone = pin.sensor_input_a && offsetSteps == 16'h0;
          end else if (homeDir ? pin.fls : pin.rls) begin
            setA.nohomes = passedLim;
          end
        end else if (homeMode == `SDIAL_MODE_2S) begin
          homeDone = (homeDir ? pin.fls : pin.rls) && offsetSteps == 16'h0;
        end
        if (homeMode != `SDIAL_MODE_1D && !passedLim) begin
          setA.lsrev = homeDir ? pin.rls : pin.fls;
        end
      end
      sdial_pkg::HM_DECEL: begin
        setA.homeop = !pin.home;
        homeDone = pin.home && homeCnt == 16'h0 && offsetSteps == 16'h0;
      end
      sdial_pkg::HM_OFFS: begin
        setA.offset = limEdge;
        homeDone = !limEdge && homeCnt == offsetSteps;
      end
      default: ;
    endcase
    setA.bothls = homeStart && pin.fls && pin.rls;
    setA.nohome = absMoveStart && !homed;
    setA.hwot = limAlm && !homing && (pin.fls || pin.rls);
    setA.swot = swAlm && !homing && homed && (pos >= swPos || pos <= swNeg);
    setA.ovcur = flt.ovcur;
    setA.heat = flt.heat;
    setA.ovvolt = flt.ovvolt;
    setA.unvolt = flt.unvolt;
    setA.pulse = flt.pulse;
    setA.mem = flt.mem;
    setA.cpu = flt.cpu;
    setA.comerr = errLim != 8'h0 && errCnt >= errLim;
    setA.comto = commTo != 32'h0 && idleCnt >= commTo;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hst <= sdial_pkg::HM_IDLE;
      homeDir <= 1'b1;
      passedLim <= 1'b0;
      homeCnt <= '0;
    end else if (hst != sdial_pkg::HM_IDLE && (alarmAny || pin.stop || homeDone)) begin
      hst <= sdial_pkg::HM_IDLE;
    end else begin
      unique case (hst)
        sdial_pkg::HM_IDLE: begin
          if (homeStart && !alarmAny && !(pin.fls && pin.rls)) begin
            hst <= sdial_pkg::HM_SEEK;
            homeDir <= 1'b1;
            passedLim <= 1'b0;
            homeCnt <= '0;
          end
        end
        sdial_pkg::HM_SEEK: begin
          if (homeMode == `SDIAL_MODE_1D && pin.home) begin
            hst <= sdial_pkg::HM_DECEL;
            homeCnt <= `SDIAL_DECEL_STEPS;
          end else if (homeMode == `SDIAL_MODE_3S && pin.home) begin
            hst <= sdial_pkg::HM_OFFS;
            homeCnt <= '0;
          end else if (homeMode == `SDIAL_MODE_2S && (homeDir ? pin.fls : pin.rls)) begin
            hst <= sdial_pkg::HM_OFFS;
            homeDir <= !homeDir;
            homeCnt <= '0;
          end else if (homeMode == `SDIAL_MODE_3S && !passedLim &&
            (homeDir ? pin.fls : pin.rls)) begin
            homeDir <= !homeDir;
            passedLim <= 1'b1;
          end
        end
        sdial_pkg::HM_DECEL: begin
          if (homeCnt == 16'h0) begin
            hst <= sdial_pkg::HM_OFFS;
          end else if (stepTick) begin
            homeCnt <= homeCnt - 16'h1;
          end
        end
        sdial_pkg::HM_OFFS: begin
          if (stepTick) begin
            homeCnt <= homeCnt + 16'h1;
          end
        end
        default: hst <= sdial_pkg::HM_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Link supervision
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errCnt <= '0;
      idleCnt <= '0;
    end else begin
      if (commFrame) begin
        errCnt <= '0;
      end else if (commError && errCnt != 8'hFF) begin
        errCnt <= errCnt + 8'h1;
      end
      if (commFrame || commError) begin
        idleCnt <= '0;
      end else if (idleCnt != 32'hFFFFFFFF) begin
        idleCnt <= idleCnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Alarm latch and indication
  // ----------------------------------------
  // A cause present during the clear edge re-latches at once: set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm <= '0;
    end else begin
      alarm <= (clrEdge ? '0 : alarm) | setA;
    end
  end

  function automatic logic [3:0] blink_of(input sdial_pkg::sdial_alarm_t a);
    if (a.ovcur) begin
      return `SDIAL_BL_OVCUR;
    end else if (a.heat) begin
      return `SDIAL_BL_HEAT;
    end else if (a.ovvolt || a.unvolt) begin
      return `SDIAL_BL_VOLT;
    end else if (a.pulse) begin
      return `SDIAL_BL_PULSE;
    end else if (a.mem) begin
      return `SDIAL_BL_MEM;
    end else if (|a[16:5]) begin
      return `SDIAL_BL_MOTION;
    end
    return 4'h0;
  endfunction

  assign blinkCount = blink_of(alarm);

  sdial_blink #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC),
    .GAP_CYC(BLINK_GAP_CYC)
  ) u_blink (
    .clk(clk),
    .rstn(rstn),
    .count(blinkCount),
    .steady(alarm.cpu),
    .led(alarmLed)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarmContactOutput <= 1'b1;
    end else begin
      alarmContactOutput <= !alarmAny;
    end
  end
endmodule
`default_nettype wire

// ### tb/sdial_chk.sv
// Purpose: Port checks for sdial_top
// Assumes: Pins pass the sync in four edges
// Notes: Eight cycles cover sync plus latch
`timescale 1ns/1ps
`default_nettype none
module sdial_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic forwardRunInput,
  input wire logic reverseRunInput,
  input wire logic stopInput,
  input wire sdial_pkg::sdial_fault_t faultIn,
  input wire logic alarmContactOutput,
  input wire logic stepPulse,
  input wire logic stepDir,
  input wire logic alarmLed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------
  // Checks
  // ------
  AST_FWD_DIR: assert property (
    (forwardRunInput && !reverseRunInput)[*8] ##0 stepPulse |-> stepDir) else $error("dir");
  AST_REV_DIR: assert property (
    (reverseRunInput && !forwardRunInput)[*8] ##0 stepPulse |-> !stepDir) else $error("dir");
  AST_BOTH_RUN: assert property (
    (forwardRunInput && reverseRunInput)[*8] |-> !stepPulse) else $error("both");
  AST_STOP: assert property (stopInput[*8] |-> !stepPulse) else $error("stop");
  AST_PULSE_ONE: assert property (stepPulse |=> !stepPulse) else $error("pulse");
  AST_OVCUR: assert property (
    faultIn.ovcur[*8] |-> !alarmContactOutput) else $error("ovcur");
  AST_VOLT: assert property (
    faultIn.unvolt[*8] |-> !alarmContactOutput) else $error("volt");
  AST_CPU: assert property (faultIn.cpu[*8] |-> alarmLed) else $error("cpu");
  cover property (stepPulse && stepDir);
  cover property (!alarmContactOutput);
  cover property (faultIn.cpu && alarmLed);
endmodule
`default_nettype wire

// ### tb/sdial_sensor_model.sv
// Purpose: Host pins plus home and limit sensors
// Assumes: Shaft position follows step pulses
// Notes: Host bits pass through, sensors add
`timescale 1ns/1ps
`default_nettype none
module sdial_sensor_model #(
  parameter int HOME_AT = 8,
  parameter int LIM = 40
) (
  input wire logic clk,
  input wire logic rstn,
  input wire sdial_pkg::sdial_pins_t cmd,
  input wire logic stepPulse,
  input wire logic stepDir,
  output var sdial_pkg::sdial_pins_t pins
);
  int pos;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pos <= 0;
    else if (stepPulse) pos <= stepDir ? pos + 1 : pos - 1;
  end
  always_comb begin
    pins = cmd;
    pins.home = cmd.home | (pos == HOME_AT);
    pins.fls = cmd.fls | (pos >= LIM);
    pins.rls = cmd.rls | (pos <= -LIM);
  end
endmodule
`default_nettype wire

// ### tb/sdial_tb_top.sv
// Purpose: Self-checking bench for sdial_top
// Assumes: Short blink counts 4, 4, 16
// Notes: Status is read back exactly
`timescale 1ns/1ps
`default_nettype none
module sdial_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  sdial_pkg::sdial_pins_t cmd = 8'h00;
  sdial_pkg::sdial_pins_t pins;
  sdial_pkg::sdial_fault_t faultIn = 7'h00;
  logic commFrame = 1'b0;
  logic commError = 1'b0;
  logic absMoveStart = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic alarmContactOutput, shaftAnglePulseOutput, stepPulse, stepDir, alarmLed;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  sdial_sensor_model i_model (.clk, .rstn, .cmd, .stepPulse, .stepDir, .pins);
  sdial_top #(.BLINK_ON_CYC(4), .BLINK_OFF_CYC(4), .BLINK_GAP_CYC(16)) i_dut (
    .clk, .rstn, .forwardRunInput(pins.fwd), .reverseRunInput(pins.rev),
    .stopInput(pins.stop), .alarmClearInput(pins.clr), .homeSensorInput(pins.home),
    .forwardLimitInput(pins.fls), .reverseLimitInput(pins.rls), .sensorInputA(pins.sensor_input_a),
    .faultIn, .commFrame, .commError, .absMoveStart, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .alarmContactOutput, .shaftAnglePulseOutput, .stepPulse, .stepDir, .alarmLed);
  // -------
  // Helpers
  // -------
  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at its closing edge
    @(posedge clk);
    check(regRdata, exp);
  endtask
  // Led counts high cycles, otherwise step pulses are counted
  task automatic count(input int len, input bit led, output int c);
    c = 0;
    repeat (len) begin
      @(posedge clk);
      c += led ? alarmLed : stepPulse;
    end
  endtask
  // Ten dark cycles only occur in the pause between flash groups
  task automatic blinks(output int n);
    int dark;
    logic prev;
    n = 0;
    dark = 0;
    prev = 1'b0;
    while (dark < 10) begin
      @(posedge clk);
      dark = alarmLed ? 0 : dark + 1;
    end
    dark = 0;
    while (dark < 10) begin
      @(posedge clk);
      n += (alarmLed && !prev);
      dark = alarmLed ? 0 : dark + 1;
      prev = alarmLed;
    end
  endtask
  task automatic clear_chk(input logic [31:0] st);
    rd(8'h1C, st);
    check({31'h0, alarmContactOutput}, 32'h0);
    cmd.clr <= 1'b1;
    repeat (8) @(posedge clk);
    cmd.clr <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h0, alarmContactOutput}, 32'h1);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs();
    rd(8'h04, 32'h0000_03E8);
    rd(8'h10, 32'h0000_0003);
    rd(8'h0C, 32'h8000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
  endtask
  task automatic t_run();
    int c;
    wr(8'h04, 32'h0000_0002);
    cmd.fwd <= 1'b1;
    repeat (20) @(posedge clk);
    count(30, 1'b0, c);
    check(c, 10);
    check({31'h0, stepDir}, 32'h1);
    cmd.rev <= 1'b1;
    repeat (10) @(posedge clk);
    count(20, 1'b0, c);
    check(c, 0);
    cmd.fwd <= 1'b0;
    repeat (20) @(posedge clk);
    count(30, 1'b0, c);
    check(c, 10);
    check({31'h0, stepDir}, 32'h0);
    cmd.stop <= 1'b1;
    repeat (10) @(posedge clk);
    count(30, 1'b0, c);
    check(c, 0);
    cmd <= 8'h00;
  endtask
  task automatic t_faults();
    int n;
    int bl[6] = '{5, 2, 3, 3, 2, 9};
    for (int i = 0; i < 7; i++) begin
      faultIn <= 7'h01 << i;
      repeat (12) @(posedge clk);
      if (i < 6) blinks(n);
      else count(40, 1'b1, n);
      check(n, (i < 6) ? bl[i] : 40);
      faultIn <= 7'h00;
      repeat (8) @(posedge clk);
      clear_chk((i < 6) ? 32'h1 << i : 32'h0002_0000);
    end
  endtask
  task automatic t_events();
    repeat (3) begin
      @(posedge clk);
      commError <= 1'b1;
      @(posedge clk);
      commError <= 1'b0;
    end
    // A good frame ends the error run, so the latched alarm can be cleared
    @(posedge clk);
    commFrame <= 1'b1;
    @(posedge clk);
    commFrame <= 1'b0;
    repeat (4) @(posedge clk);
    clear_chk(32'h0000_8000);
    absMoveStart <= 1'b1;
    @(posedge clk);
    absMoveStart <= 1'b0;
    repeat (4) @(posedge clk);
    clear_chk(32'h0000_0040);
    cmd.fls <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h1C, 32'h0);
    wr(8'h00, 32'h1);
    repeat (8) @(posedge clk);
    cmd.fls <= 1'b0;
    repeat (8) @(posedge clk);
    clear_chk(32'h0000_1000);
  endtask
  task automatic t_home();
    int steps;
    logic seen;
    steps = 0;
    seen = 1'b0;
    cmd.fls <= 1'b1;
    cmd.rls <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h00, 32'h0000_0010);
    cmd.fls <= 1'b0;
    cmd.rls <= 1'b0;
    repeat (8) @(posedge clk);
    clear_chk(32'h0000_1080);
    cmd.sensor_input_a <= 1'b1;
    wr(8'h00, 32'h0000_0010);
    repeat (300) @(posedge clk);
    rd(8'h1C, 32'h0004_0000);
    check({31'h0, shaftAnglePulseOutput}, 32'h1);
    cmd.fwd <= 1'b1;
    // Angle output settles one edge after the step that moves it
    repeat (60) begin
      @(posedge clk);
      if (seen) check({31'h0, shaftAnglePulseOutput}, {31'h0, steps % 4 == 0});
      seen = stepPulse;
      steps += stepPulse;
    end
    cmd <= 8'h00;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_run();
    t_faults();
    t_events();
    t_home();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: timeout", $time);
    conclude();
  end
endmodule
bind sdial_top sdial_chk i_chk (.clk, .rstn, .forwardRunInput, .reverseRunInput, .stopInput,
  .faultIn, .alarmContactOutput, .stepPulse, .stepDir, .alarmLed);
`default_nettype wire
